// File: verilog/mlu_params.svh
// Constants for the multiply instruction unit: opcode fields and bit positions.
// Assumes the 32-bit instruction word with the first halfword in bits 15:0.
`ifndef MLU_PARAMS_SVH
`define MLU_PARAMS_SVH

// Field positions of the first halfword
`define MLU_R2_MSB        15
`define MLU_R2_LSB        11
`define MLU_OPC_MSB       10
`define MLU_OPC_LSB       5
`define MLU_R1_MSB        4
`define MLU_R1_LSB        0

// Field positions of the second halfword
`define MLU_R3_MSB        31
`define MLU_R3_LSB        27
`define MLU_SUB_MSB       26
`define MLU_SUB_LSB       16
`define MLU_XSUB_MSB      26
`define MLU_XSUB_LSB      22
`define MLU_IMMHI_MSB     21
`define MLU_IMMHI_LSB     18
`define MLU_XTAIL_MSB     17
`define MLU_XTAIL_LSB     16

// Opcodes
`define MLU_OPC_EXT       6'h3F
`define MLU_OPC_HALF_REG  6'h07
`define MLU_OPC_HALF_IMM  6'h17
`define MLU_SUB_WORD_REG  11'h220
`define MLU_XSUB_WORD_IMM 5'h09
`define MLU_XTAIL_SIGNED  2'h0

// Widths and reset values
`define MLU_IMM5_W        5
`define MLU_IMM9_W        9
`define MLU_ZERO_REG      5'h00
`define MLU_RST_DATA      32'h0000_0000

`endif

// File: verilog/mlu_pkg.sv
// Types shared by the multiply instruction unit.
// Assumes nothing of its surroundings.
package mlu_pkg;

    // Kind of multiply decoded from the instruction word
    typedef enum logic [2:0]
    {
        MLU_OP_NONE,
        MLU_OP_WORD_REG,
        MLU_OP_WORD_IMM,
        MLU_OP_HALF_REG,
        MLU_OP_HALF_IMM
    } mlu_op_t;

endpackage : mlu_pkg

// File: verilog/mlu_multiply_unit.sv
// Multiply instruction unit: decodes the word and halfword multiplies and forms the
// register file write-back. Assumes the register file presents the contents of the
// registers named in bits 4:0 and 15:11 in the same cycle as the instruction, and
// that its write ports ignore the zero register.
// Function
// RULE1: Register word multiply puts the high product word in the third register and low in the second.
// RULE2: Immediate word multiply sign-extends the 9-bit immediate and splits the product likewise.
// RULE3: When the low and high destinations coincide, that register ends up with the high word.
// RULE4: The issuer avoids a register word multiply whose first source equals the high destination.
// RULE5: The 9-bit immediate is joined from a low 5-bit field and a high 4-bit field.
// RULE6: Register halfword multiply writes low halves' 32-bit product to the second register.
// RULE7: Immediate halfword multiply sign-extends the 5-bit immediate and writes the second register.
// RULE8: Upper halves of both sources never affect a halfword product.
// RULE9: The issuer never names the zero register as halfword multiply destination.
// RULE10: No multiply ever changes the carry, overflow, sign, zero or saturation flags.
// RULE11: Halfword forms are recognised by opcodes 000111 and 010111, immediate in bits 4:0.
`timescale 1ns/10ps
`include "mlu_params.svh"

module mlu_multiply_unit
#(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 5
)
(
    // Clock, reset, enable
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Issue from the instruction decoder
    input  wire logic              issue_valid,
    input  wire logic [31:0]       issue_instr,
    // Register file read data
    input  wire logic [DATA_W-1:0] src1_data,
    input  wire logic [DATA_W-1:0] src2_data,
    // Low result write port
    output logic                   lo_wr_en_q,
    output logic [ADDR_W-1:0]      lo_wr_addr_q,
    output logic [DATA_W-1:0]      lo_wr_data_q,
    // High result write port
    output logic                   hi_wr_en_q,
    output logic [ADDR_W-1:0]      hi_wr_addr_q,
    output logic [DATA_W-1:0]      hi_wr_data_q,
    // Status toward the core
    output logic                   flag_wr_en_q,
    output logic                   done_q,
    output logic                   unsupported_q,
    output logic                   hazard_q
);

    // Field layout is fixed by the instruction format, so other widths cannot be served
    if (DATA_W != 32 || ADDR_W != 5)
    begin : gen_bad_width
        $error("mlu_multiply_unit serves only 32-bit data and 5-bit register numbers");
    end

    // Decoded fields and datapath values
    mlu_pkg::mlu_op_t  op;
    logic [ADDR_W-1:0] r1_num;
    logic [ADDR_W-1:0] r2_num;
    logic [ADDR_W-1:0] r3_num;
    logic [8:0]        imm9;
    logic [4:0]        imm5;
    logic [31:0]       word_b;
    logic [15:0]       half_b;
    logic [63:0]       word_prod;
    logic [31:0]       half_prod;

    // Next values of the registered outputs
    logic              lo_wr_en_d;
    logic [ADDR_W-1:0] lo_wr_addr_d;
    logic [DATA_W-1:0] lo_wr_data_d;
    logic              hi_wr_en_d;
    logic [ADDR_W-1:0] hi_wr_addr_d;
    logic [DATA_W-1:0] hi_wr_data_d;
    logic              flag_wr_en_d;
    logic              done_d;
    logic              unsupported_d;
    logic              hazard_d;

    always_comb
    begin
        r1_num = issue_instr[`MLU_R1_MSB:`MLU_R1_LSB];
        r2_num = issue_instr[`MLU_R2_MSB:`MLU_R2_LSB];
        r3_num = issue_instr[`MLU_R3_MSB:`MLU_R3_LSB];
        imm5   = issue_instr[`MLU_R1_MSB:`MLU_R1_LSB];                            // RULE11
        imm9   = {issue_instr[`MLU_IMMHI_MSB:`MLU_IMMHI_LSB], imm5};              // RULE5

        // Decode; halfword forms live entirely in the first halfword
        op = mlu_pkg::MLU_OP_NONE;
        case (issue_instr[`MLU_OPC_MSB:`MLU_OPC_LSB])
            `MLU_OPC_HALF_REG:
            begin
                op = mlu_pkg::MLU_OP_HALF_REG;                                    // RULE11
            end
            `MLU_OPC_HALF_IMM:
            begin
                op = mlu_pkg::MLU_OP_HALF_IMM;                                    // RULE11
            end
            `MLU_OPC_EXT:
            begin
                // Word forms share the extended opcode and differ in the second halfword
                if (issue_instr[`MLU_SUB_MSB:`MLU_SUB_LSB] == `MLU_SUB_WORD_REG)
                begin
                    op = mlu_pkg::MLU_OP_WORD_REG;
                end
                else if (issue_instr[`MLU_XSUB_MSB:`MLU_XSUB_LSB] == `MLU_XSUB_WORD_IMM &&
                         issue_instr[`MLU_XTAIL_MSB:`MLU_XTAIL_LSB] == `MLU_XTAIL_SIGNED)
                begin
                    op = mlu_pkg::MLU_OP_WORD_IMM;
                end
                else
                begin
                    // Other tails, the unsigned variant among them, are refused
                    op = mlu_pkg::MLU_OP_NONE;
                end
            end
            default:
            begin
                op = mlu_pkg::MLU_OP_NONE;
            end
        endcase

        // Second multiplicand: register or sign-extended immediate
        if (op == mlu_pkg::MLU_OP_WORD_IMM)
        begin
            word_b = {{(32 - `MLU_IMM9_W){imm9[8]}}, imm9};                       // RULE2
        end
        else
        begin
            word_b = src1_data;                                                   // RULE1
        end
        if (op == mlu_pkg::MLU_OP_HALF_IMM)
        begin
            half_b = {{(16 - `MLU_IMM5_W){imm5[4]}}, imm5};                       // RULE7
        end
        else
        begin
            half_b = src1_data[15:0];                                             // RULE6
        end

        // Full 64-bit signed product; both halves are needed for the split write
        word_prod = 64'($signed(src2_data)) * 64'($signed(word_b));               // RULE1 RULE2
        // Only the low halves enter the halfword multiplier
        half_prod = 32'($signed(src2_data[15:0])) * 32'($signed(half_b));         // RULE8

        lo_wr_en_d    = 1'b0;
        lo_wr_addr_d  = r2_num;
        lo_wr_data_d  = `MLU_RST_DATA;
        hi_wr_en_d    = 1'b0;
        hi_wr_addr_d  = r3_num;
        hi_wr_data_d  = `MLU_RST_DATA;
        // The flag port is never asserted, so the flags keep their values
        flag_wr_en_d  = 1'b0;                                                     // RULE10
        done_d        = 1'b0;
        unsupported_d = 1'b0;
        hazard_d      = 1'b0;

        // Nothing is written unless an instruction is issued this cycle
        if (issue_valid)
        begin
            case (op)
                mlu_pkg::MLU_OP_WORD_REG, mlu_pkg::MLU_OP_WORD_IMM:
                begin
                    done_d       = 1'b1;
                    hi_wr_en_d   = 1'b1;                                          // RULE1 RULE2
                    hi_wr_data_d = word_prod[63:32];
                    lo_wr_data_d = word_prod[31:0];
                    // Dropping the low write avoids two ports racing on one register
                    lo_wr_en_d   = (r2_num != r3_num);                            // RULE3
                    // Flag a combination whose result is not guaranteed
                    hazard_d     = (op == mlu_pkg::MLU_OP_WORD_REG) &&
                                   (r1_num == r3_num) && (r1_num != r2_num) &&
                                   (r1_num != `MLU_ZERO_REG) &&
                                   (r3_num != `MLU_ZERO_REG);                     // RULE4
                end
                mlu_pkg::MLU_OP_HALF_REG, mlu_pkg::MLU_OP_HALF_IMM:
                begin
                    done_d       = 1'b1;
                    // Zero destination is left to the issuer; the file ignores it
                    lo_wr_en_d   = 1'b1;                                          // RULE6 RULE7
                    lo_wr_data_d = half_prod;
                end
                default:
                begin
                    unsupported_d = 1'b1;
                end
            endcase
        end
    end

    // Outputs hold while ce is low, so a stalled core sees a steady write request
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lo_wr_en_q    <= 1'b0;
            lo_wr_addr_q  <= `MLU_ZERO_REG;
            lo_wr_data_q  <= `MLU_RST_DATA;
            hi_wr_en_q    <= 1'b0;
            hi_wr_addr_q  <= `MLU_ZERO_REG;
            hi_wr_data_q  <= `MLU_RST_DATA;
            flag_wr_en_q  <= 1'b0;
            done_q        <= 1'b0;
            unsupported_q <= 1'b0;
            hazard_q      <= 1'b0;
        end
        else if (ce)
        begin
            lo_wr_en_q    <= lo_wr_en_d;
            lo_wr_addr_q  <= lo_wr_addr_d;
            lo_wr_data_q  <= lo_wr_data_d;
            hi_wr_en_q    <= hi_wr_en_d;
            hi_wr_addr_q  <= hi_wr_addr_d;
            hi_wr_data_q  <= hi_wr_data_d;
            flag_wr_en_q  <= flag_wr_en_d;
            done_q        <= done_d;
            unsupported_q <= unsupported_d;
            hazard_q      <= hazard_d;
        end
    end

endmodule : mlu_multiply_unit

// File: sim/mlu_regfile_model.sv
// Register file model for the multiply unit: two read ports, two write ports.
// Assumes reads follow the read addresses in the same cycle; the zero register reads 0.
`timescale 1ns/10ps
module mlu_regfile_model
(
    input wire logic clk, ce, lo_en, hi_en,
    input wire logic [4:0] rd1_addr, rd2_addr, lo_addr, hi_addr,
    input wire logic [31:0] lo_data, hi_data,
    output logic [31:0] rd1_data, rd2_data
);
    logic [31:0] regs_q [32];
    initial for (int i = 0; i < 32; i++) regs_q[i] = i * 32'h9E37_79B9;
    assign rd1_data = (rd1_addr == 5'h00) ? 32'h0000_0000 : regs_q[rd1_addr];
    assign rd2_data = (rd2_addr == 5'h00) ? 32'h0000_0000 : regs_q[rd2_addr];
    // High write issued last so it wins when both ports name one register
    always @(posedge clk)
        if (ce)
        begin
            if (lo_en) regs_q[lo_addr] <= lo_data;
            if (hi_en) regs_q[hi_addr] <= hi_data;
        end
endmodule : mlu_regfile_model

// File: sim/mlu_multiply_unit_chk.sv
// Assertions on the multiply unit ports.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/10ps
module mlu_multiply_unit_chk
#(
    parameter int DATA_W = 32,
    parameter int ADDR_W = 5
)
(
    input wire logic clk, rst, ce, issue_valid, lo_wr_en_q, hi_wr_en_q,
    input wire logic flag_wr_en_q, done_q, unsupported_q, hazard_q,
    input wire logic [31:0] issue_instr,
    input wire logic [DATA_W-1:0] src1_data, src2_data, lo_wr_data_q, hi_wr_data_q,
    input wire logic [ADDR_W-1:0] lo_wr_addr_q, hi_wr_addr_q
);
    logic [5:0] opc;
    logic go, wm, hm;
    logic [31:0] ws, hp;
    logic [15:0] hs;
    logic [63:0] wp;
    assign opc = issue_instr[10:5];
    assign go = ce && issue_valid;
    assign wm = opc == 6'h3F && (issue_instr[26:16] == 11'h220
                || (issue_instr[26:22] == 5'h09 && issue_instr[17:16] == 2'h0));
    assign hm = opc == 6'h07 || opc == 6'h17;
    assign ws = (issue_instr[26:22] == 5'h09)
              ? {{23{issue_instr[21]}}, issue_instr[21:18], issue_instr[4:0]} : src1_data;
    assign wp = {{32{src2_data[31]}}, src2_data} * {{32{ws[31]}}, ws};
    assign hs = (opc == 6'h17) ? {{11{issue_instr[4]}}, issue_instr[4:0]} : src1_data[15:0];
    assign hp = {{16{src2_data[15]}}, src2_data[15:0]} * {{16{hs[15]}}, hs};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_word_high: assert property (go && wm |=> hi_wr_en_q && hi_wr_data_q == $past(wp[63:32])
        && hi_wr_addr_q == $past(issue_instr[31:27])) else $error("word high result wrong");
    a_word_low: assert property (go && wm && issue_instr[15:11] != issue_instr[31:27]
        |=> lo_wr_en_q && lo_wr_data_q == $past(wp[31:0])) else $error("word low result wrong");
    a_same_dest: assert property (go && wm && issue_instr[15:11] == issue_instr[31:27]
        |=> !lo_wr_en_q && hi_wr_en_q) else $error("shared destination not high word");
    a_half_data: assert property (go && hm |=> lo_wr_en_q && !hi_wr_en_q
        && lo_wr_data_q == $past(hp)) else $error("halfword product wrong");
    a_half_addr: assert property (go && hm |=> lo_wr_addr_q == $past(issue_instr[15:11]))
        else $error("halfword destination wrong");
    a_flags_kept: assert property (!flag_wr_en_q) else $error("flags written");
    a_mult_done: assert property (go |=> done_q == $past(wm || hm)
        && unsupported_q == $past(!(wm || hm))) else $error("decode status wrong");
    a_hazard_seen: assert property (go && wm && issue_instr[26:22] != 5'h09
        && issue_instr[4:0] == issue_instr[31:27] && issue_instr[4:0] != issue_instr[15:11]
        && issue_instr[4:0] != 5'h00 |=> hazard_q) else $error("hazard not flagged");
endmodule : mlu_multiply_unit_chk
bind mlu_multiply_unit mlu_multiply_unit_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W))
    mlu_multiply_unit_chk_inst (.clk, .rst, .ce, .issue_valid, .issue_instr, .src1_data,
    .src2_data, .lo_wr_en_q, .lo_wr_addr_q, .lo_wr_data_q, .hi_wr_en_q, .hi_wr_addr_q,
    .hi_wr_data_q, .flag_wr_en_q, .done_q, .unsupported_q, .hazard_q);

// File: sim/multiply_instruction_unit_test.sv
// Self-checking bench for the multiply unit with a register file model.
// Assumes the checker is bound in and the model starts from a fixed pattern.
`timescale 1ns/10ps
module multiply_instruction_unit_test;
    logic clk = 0, rst = 1, ce = 0, issue_valid = 0;
    logic [31:0] issue_instr = 0, src1_data, src2_data, lo_wr_data_q, hi_wr_data_q;
    logic lo_wr_en_q, hi_wr_en_q, flag_wr_en_q, done_q, unsupported_q, hazard_q;
    logic [4:0] lo_wr_addr_q, hi_wr_addr_q;
    logic [31:0] m [32];
    int failures = 0, total_checks = 0;
    always #25 clk = ~clk;
    mlu_multiply_unit mlu_multiply_unit_inst (.clk, .rst, .ce, .issue_valid, .issue_instr,
        .src1_data, .src2_data, .lo_wr_en_q, .lo_wr_addr_q, .lo_wr_data_q, .hi_wr_en_q,
        .hi_wr_addr_q, .hi_wr_data_q, .flag_wr_en_q, .done_q, .unsupported_q, .hazard_q);
    mlu_regfile_model mlu_regfile_model_inst (.clk, .ce, .lo_en(lo_wr_en_q), .hi_en(hi_wr_en_q),
        .rd1_addr(issue_instr[4:0]), .rd2_addr(issue_instr[15:11]), .lo_addr(lo_wr_addr_q),
        .hi_addr(hi_wr_addr_q), .lo_data(lo_wr_data_q), .hi_data(hi_wr_data_q),
        .rd1_data(src1_data), .rd2_data(src2_data));
    function automatic logic [63:0] smul(input logic [31:0] a, b);
        return {{32{a[31]}}, a} * {{32{b[31]}}, b};
    endfunction : smul
    task automatic chk(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        if (failures == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic run(input logic [31:0] ins);
        logic [4:0] r1, r2, r3;
        logic [31:0] a, b, w;
        logic [15:0] h;
        logic [63:0] p;
        logic wd, hf, im;
        r1 = ins[4:0];
        r2 = ins[15:11];
        r3 = ins[31:27];
        wd = ins[10:5] == 6'h3F && (ins[26:16] == 11'h220
             || (ins[26:22] == 5'h09 && ins[17:16] == 2'h0));
        hf = ins[10:5] == 6'h07 || ins[10:5] == 6'h17;
        im = ins[26:22] == 5'h09;
        @(posedge clk);
        #2 issue_valid = 1;
        issue_instr = ins;
        #1 a = m[r1];
        b = m[r2];
        chk(src1_data, a); chk(src2_data, b);
        @(posedge clk);
        #2 issue_valid = 0;
        w = im ? {{23{ins[21]}}, ins[21:18], ins[4:0]} : a;
        h = (ins[10:5] == 6'h17) ? {{11{ins[4]}}, ins[4:0]} : a[15:0];
        p = wd ? smul(b, w) : smul({{16{b[15]}}, b[15:0]}, {{16{h[15]}}, h});
        chk(done_q, wd || hf); chk(unsupported_q, !(wd || hf));
        chk(hi_wr_en_q, wd); chk(lo_wr_en_q, hf || (wd && r2 != r3));
        chk(flag_wr_en_q, 0); chk(hazard_q, wd && !im && r1 == r3 && r1 != r2 && r1 != 0);
        if (wd) chk(hi_wr_data_q, p[63:32]);
        if (wd) chk(hi_wr_addr_q, r3);
        if (hf || (wd && r2 != r3)) chk(lo_wr_data_q, p[31:0]);
        if (hf || (wd && r2 != r3)) chk(lo_wr_addr_q, r2);
        if (wd || hf) m[r2] = p[31:0];
        if (wd) m[r3] = p[63:32];
        m[0] = 0;
    endtask : run
    initial
    begin
        logic [4:0] r1, r2, r3;
        logic [8:0] iv;
        int k;
        for (int i = 0; i < 32; i++) m[i] = i * 32'h9E37_79B9;
        void'($urandom(91));
        repeat (4) @(posedge clk);
        #2 rst = 0;
        ce = 1;
        chk({flag_wr_en_q, lo_wr_en_q, hi_wr_en_q, done_q, unsupported_q, hazard_q}, 0);
        run({5'd4, 11'h220, 5'd4, 6'h3F, 5'd7});
        run({5'd5, 5'h09, 4'h8, 2'h0, 5'd6, 6'h3F, 5'h00});
        run({5'd8, 5'h09, 4'h7, 2'h0, 5'd8, 6'h3F, 5'h1F});
        run({16'h0, 5'd9, 6'h17, 5'h10});
        run({16'h0, 5'd9, 6'h07, 5'd0});
        ce = 0;
        @(posedge clk);
        #2 chk(done_q, 1); chk(lo_wr_en_q, 1);
        ce = 1;
        run({5'd3, 11'h220, 5'd4, 6'h3F, 5'd3});
        run({16'h0, 5'd2, 6'h00, 5'd1});
        run({5'd5, 5'h09, 4'h3, 2'h2, 5'd6, 6'h3F, 5'h01});
        repeat (300)
        begin
            k = $urandom % 5;
            {r1, r2, r3, iv} = 24'($urandom);
            if (r2 == 0) r2 = 5'd1;
            if (r1 == r3 && r1 != r2 && r1 != 0) r3 = r1 ^ 5'h01;
            case (k)
                0: run({r3, 11'h220, r2, 6'h3F, r1});
                1: run({r3, 5'h09, iv[8:5], 2'h0, r2, 6'h3F, iv[4:0]});
                2: run({16'h0, r2, 6'h07, r1});
                3: run({16'h0, r2, 6'h17, iv[4:0]});
                default: run({iv, r3, 2'h0, r2, 6'h00, r1});
            endcase
        end
        report_and_stop();
    end
    initial
    begin
        #500000;
        failures++;
        report_and_stop();
    end
endmodule : multiply_instruction_unit_test
